// ==== motor_pwm_regs.svh ====
`ifndef MOTOR_PWM_REGS_SVH
`define MOTOR_PWM_REGS_SVH

// System clock rate and the times that are counted in it
`define SYS_CLK_MHZ        20
`define DEAD_TIME_NS       600
`define DEAD_CYC           ((`DEAD_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define PWM_PERIOD_US      50
`define PWM_PERIOD_CYC     (`PWM_PERIOD_US * `SYS_CLK_MHZ)
`define OSC_SETTLE_MS      50
`define OSC_SETTLE_CYC     (`OSC_SETTLE_MS * `SYS_CLK_MHZ * 1000)
`define PRECHARGE_MS       3000
`define PRECHARGE_CYC      (`PRECHARGE_MS * `SYS_CLK_MHZ * 1000)
`define CONTACT_SETTLE_MS  1000
`define CONTACT_SETTLE_CYC (`CONTACT_SETTLE_MS * `SYS_CLK_MHZ * 1000)

// Calibration and measurement
`define CAL_SAMPLES        8
`define CAL_SHIFT          3
`define ADC_MID            8'h80
`define SPEED_MAX          16'hFFFF

// Oscillator control codes
`define OSC_KEY_FIRST      8'hE7
`define OSC_KEY_SECOND     8'h18
`define OSC_CMD_EXT_EN     8'h01
`define OSC_CMD_SWITCH     8'h02

`endif

// ==== motor_pwm_pkg.sv ====
package motor_pwm_pkg;

  typedef enum logic [7:0] {
    OSC_LOCKED = 8'h01,
    OSC_KEY    = 8'h02,
    OSC_OPEN   = 8'h04,
    OSC_SETTLE = 8'h08,
    OSC_RELOCK = 8'h10,
    OSC_KEY2   = 8'h20,
    OSC_OPEN2  = 8'h40,
    OSC_RUN    = 8'h80
  } osc_state_t;

  typedef enum logic [4:0] {
    SEQ_IDLE      = 5'h01,
    SEQ_CAL       = 5'h02,
    SEQ_PRECHARGE = 5'h04,
    SEQ_SETTLE    = 5'h08,
    SEQ_RUN       = 5'h10
  } seq_state_t;

endpackage

// ==== dead_time_pair.sv ====
`timescale 1ns/1ps
`default_nettype none
module dead_time_pair #(
  parameter int unsigned DEAD_CYC = 12
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic demand,
  input  wire logic kill,
  output logic      high_on,
  output logic      low_on
);
  localparam int unsigned CW = $clog2(DEAD_CYC + 1);

  logic          target_q;
  logic [CW-1:0] dead_q;
  logic [7:0]    off_cnt_q;

  // The edge that sees the change already counts as the first dead cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      target_q <= 1'b0;
      dead_q   <= CW'(DEAD_CYC - 1);
      high_on  <= 1'b0;
      low_on   <= 1'b0;
    end else if (kill || (demand != target_q)) begin
      target_q <= demand;
      dead_q   <= CW'(DEAD_CYC - 1);
      high_on  <= 1'b0;
      low_on   <= 1'b0;
    end else if (dead_q != '0) begin
      dead_q   <= dead_q - 1'b1;
      high_on  <= 1'b0;
      low_on   <= 1'b0;
    end else begin
      high_on  <= target_q;
      low_on   <= !target_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      off_cnt_q <= 8'h00;
    end else if (high_on || low_on) begin
      off_cnt_q <= 8'h00;
    end else if (off_cnt_q != 8'hFF) begin
      off_cnt_q <= off_cnt_q + 8'h01;
    end
  end

  property p_never_both;
    @(posedge ref_clk) disable iff (!resetn)
      !(high_on && low_on);
  endproperty
  a_never_both: assert property (p_never_both)
    else $error("both outputs of a pair on");

  property p_dead_before_on;
    @(posedge ref_clk) disable iff (!resetn)
      ($rose(high_on) || $rose(low_on)) |-> (off_cnt_q >= 8'(DEAD_CYC));
  endproperty
  a_dead_before_on: assert property (p_dead_before_on)
    else $error("output turned on without full dead time");

endmodule // dead_time_pair
`default_nettype wire

// ==== motor_pwm_frontend.sv ====
// Contract
// - All counts are in 20 MHz clock cycles
// - Oscillator: unlock, enable, settle, unlock, switch
// - Edge-aligned PWM with common reload edge
// - Complementary pairs with twelve-cycle dead time
// - Polarity bit chooses on or off start
// - Every reload starts one current conversion
// - Reload request pends until cleared, maskable
// - Sample precedes new gate state
// - Current result and duty are 8-bit
// - Mid-scale reading means zero current
// - Average eight zero-current samples as offset
// - Tach rising edge captures and restarts timer
// - Timer rollover saturates period at 0xFFFF
// - Overcurrent comparator shuts down PWM outputs
// - Relay off at power-up, on after startup
// - Relay after 3 s, PWM one second later
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_regs.svh"
module motor_pwm_frontend #(
  parameter int unsigned PWM_PERIOD_CYC     = `PWM_PERIOD_CYC,
  parameter int unsigned DEAD_CYC           = `DEAD_CYC,
  parameter int unsigned OSC_SETTLE_CYC     = `OSC_SETTLE_CYC,
  parameter int unsigned PRECHARGE_CYC      = `PRECHARGE_CYC,
  parameter int unsigned CONTACT_SETTLE_CYC = `CONTACT_SETTLE_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              osc_wr,
  input  wire logic [7:0]        osc_wr_data,
  output logic                   ext_osc_en,
  output logic                   sys_clk_sel,
  input  wire logic              startup_done,
  output logic                   relay_en,
  output logic                   pwm_running,
  input  wire logic [2:0][7:0]   duty,
  input  wire logic [2:0]        pwm_polarity_control,
  input  wire logic              reload_irq_en,
  input  wire logic              reload_irq_clr,
  output logic                   reload_irq,
  output logic                   adc_start,
  input  wire logic              adc_done,
  input  wire logic [7:0]        adc_data,
  output logic signed [8:0]      current_sample,
  output logic                   current_valid,
  output logic [7:0]             cal_offset,
  output logic                   cal_done,
  input  wire logic              tach_in,
  output logic [15:0]            speed_period,
  output logic                   speed_valid,
  input  wire logic              oc_cmp_in,
  input  wire logic              oc_fault_clr,
  output logic                   oc_fault,
  output logic [2:0]             gate_high,
  output logic [2:0]             gate_low
);
  localparam int unsigned PCW = $clog2(PWM_PERIOD_CYC);

  motor_pwm_pkg::osc_state_t osc_q;
  motor_pwm_pkg::osc_state_t osc_d;
  motor_pwm_pkg::seq_state_t seq_q;
  motor_pwm_pkg::seq_state_t seq_d;
  logic [31:0]     osc_wait_q;
  logic [31:0]     seq_wait_q;
  logic [3:0]      cal_cnt_q;
  logic [10:0]     cal_acc_q;
  logic [10:0]     cal_sum;
  logic            cal_busy_q;
  logic            cal_req;
  logic            cal_take;
  logic [PCW-1:0]  period_cnt_q;
  logic            reload_tick;
  logic            load_act;
  logic [2:0][7:0] duty_act_q;
  logic [2:0]      pol_act_q;
  logic [2:0]      demand_q;
  logic            reload_pend_q;
  logic [2:0]      oc_sync_q;
  logic            trip_now;
  logic            kill;
  logic [2:0]      tach_sync_q;
  logic            tach_lvl_q;
  logic            tach_rise;
  logic [15:0]     speed_cnt_q;
  logic            rolled_q;

  // Oscillator control: a wrong code drops back to OSC_LOCKED, or to OSC_RELOCK after settling
  always_comb begin
    osc_d = osc_q;
    case (osc_q)
      motor_pwm_pkg::OSC_LOCKED: begin
        if (osc_wr && (osc_wr_data == `OSC_KEY_FIRST))
          osc_d = motor_pwm_pkg::OSC_KEY;
      end
      motor_pwm_pkg::OSC_KEY: begin
        if (osc_wr)
          osc_d = (osc_wr_data == `OSC_KEY_SECOND) ?
                  motor_pwm_pkg::OSC_OPEN : motor_pwm_pkg::OSC_LOCKED;
      end
      motor_pwm_pkg::OSC_OPEN: begin
        if (osc_wr)
          osc_d = (osc_wr_data == `OSC_CMD_EXT_EN) ?
                  motor_pwm_pkg::OSC_SETTLE : motor_pwm_pkg::OSC_LOCKED;
      end
      motor_pwm_pkg::OSC_SETTLE: begin
        if (osc_wait_q == 32'h0000_0000)
          osc_d = motor_pwm_pkg::OSC_RELOCK;
      end
      motor_pwm_pkg::OSC_RELOCK: begin
        if (osc_wr && (osc_wr_data == `OSC_KEY_FIRST))
          osc_d = motor_pwm_pkg::OSC_KEY2;
      end
      motor_pwm_pkg::OSC_KEY2: begin
        if (osc_wr)
          osc_d = (osc_wr_data == `OSC_KEY_SECOND) ?
                  motor_pwm_pkg::OSC_OPEN2 : motor_pwm_pkg::OSC_RELOCK;
      end
      motor_pwm_pkg::OSC_OPEN2: begin
        if (osc_wr)
          osc_d = (osc_wr_data == `OSC_CMD_SWITCH) ?
                  motor_pwm_pkg::OSC_RUN : motor_pwm_pkg::OSC_RELOCK;
      end
      motor_pwm_pkg::OSC_RUN: osc_d = motor_pwm_pkg::OSC_RUN;
      default: osc_d = motor_pwm_pkg::OSC_LOCKED;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_q       <= motor_pwm_pkg::OSC_LOCKED;
      osc_wait_q  <= 32'h0000_0000;
      ext_osc_en  <= 1'b0;
      sys_clk_sel <= 1'b0;
    end else begin
      osc_q <= osc_d;
      if ((osc_q == motor_pwm_pkg::OSC_OPEN) &&
          (osc_d == motor_pwm_pkg::OSC_SETTLE)) begin
        osc_wait_q <= OSC_SETTLE_CYC - 1;
        ext_osc_en <= 1'b1;
      end else if (osc_wait_q != 32'h0000_0000) begin
        osc_wait_q <= osc_wait_q - 32'h0000_0001;
      end
      sys_clk_sel <= (osc_d == motor_pwm_pkg::OSC_RUN);
    end
  end

  // Startup: calibrate, precharge, close relay, settle, then modulate
  assign cal_take = (seq_q == motor_pwm_pkg::SEQ_CAL) && cal_busy_q &&
                    adc_done;
  assign cal_req  = (seq_q == motor_pwm_pkg::SEQ_CAL) && !cal_busy_q;
  assign cal_sum  = cal_acc_q + {3'b000, adc_data};

  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      motor_pwm_pkg::SEQ_IDLE: begin
        if (sys_clk_sel && startup_done)
          seq_d = motor_pwm_pkg::SEQ_CAL;
      end
      motor_pwm_pkg::SEQ_CAL: begin
        if (cal_take && (cal_cnt_q == 4'(`CAL_SAMPLES - 1)))
          seq_d = motor_pwm_pkg::SEQ_PRECHARGE;
      end
      motor_pwm_pkg::SEQ_PRECHARGE: begin
        if (seq_wait_q == 32'h0000_0000)
          seq_d = motor_pwm_pkg::SEQ_SETTLE;
      end
      motor_pwm_pkg::SEQ_SETTLE: begin
        if (seq_wait_q == 32'h0000_0000)
          seq_d = motor_pwm_pkg::SEQ_RUN;
      end
      motor_pwm_pkg::SEQ_RUN: seq_d = motor_pwm_pkg::SEQ_RUN;
      default: seq_d = motor_pwm_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seq_q       <= motor_pwm_pkg::SEQ_IDLE;
      seq_wait_q  <= 32'h0000_0000;
      relay_en    <= 1'b0;
      pwm_running <= 1'b0;
    end else begin
      seq_q <= seq_d;
      if ((seq_q == motor_pwm_pkg::SEQ_CAL) &&
          (seq_d == motor_pwm_pkg::SEQ_PRECHARGE))
        seq_wait_q <= PRECHARGE_CYC - 1;
      else if ((seq_q == motor_pwm_pkg::SEQ_PRECHARGE) &&
               (seq_d == motor_pwm_pkg::SEQ_SETTLE))
        seq_wait_q <= CONTACT_SETTLE_CYC - 1;
      else if (seq_wait_q != 32'h0000_0000)
        seq_wait_q <= seq_wait_q - 32'h0000_0001;
      relay_en    <= (seq_d == motor_pwm_pkg::SEQ_SETTLE) ||
                     (seq_d == motor_pwm_pkg::SEQ_RUN);
      pwm_running <= (seq_d == motor_pwm_pkg::SEQ_RUN);
    end
  end

  // Offset starts at mid-scale so raw readings are usable before calibration
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cal_cnt_q  <= 4'h0;
      cal_acc_q  <= 11'h000;
      cal_busy_q <= 1'b0;
      cal_offset <= `ADC_MID;
      cal_done   <= 1'b0;
    end else begin
      if (cal_req)
        cal_busy_q <= 1'b1;
      else if (adc_done)
        cal_busy_q <= 1'b0;
      if (cal_take) begin
        cal_acc_q <= cal_sum;
        cal_cnt_q <= cal_cnt_q + 4'h1;
        if (cal_cnt_q == 4'(`CAL_SAMPLES - 1)) begin
          cal_offset <= cal_sum[10:`CAL_SHIFT];
          cal_done   <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      current_sample <= 9'sh000;
      current_valid  <= 1'b0;
    end else begin
      current_valid <= adc_done && pwm_running;
      if (adc_done && pwm_running)
        current_sample <= $signed({1'b0, adc_data}) -
                          $signed({1'b0, cal_offset});
    end
  end

  // One counter for all phases; loading at run start avoids a stale cycle
  assign reload_tick = pwm_running &&
                       (period_cnt_q == PCW'(PWM_PERIOD_CYC - 1));
  assign load_act    = reload_tick ||
                       ((seq_d == motor_pwm_pkg::SEQ_RUN) && !pwm_running);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      period_cnt_q <= '0;
    end else if (!pwm_running || reload_tick) begin
      period_cnt_q <= '0;
    end else begin
      period_cnt_q <= period_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      duty_act_q <= '0;
      pol_act_q  <= 3'h0;
    end else if (load_act) begin
      duty_act_q <= duty;
      pol_act_q  <= pwm_polarity_control;
    end
  end

  // Trigger rides with the reload; gates move two edges later
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= reload_tick || cal_req;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reload_pend_q <= 1'b0;
    end else if (reload_tick) begin
      reload_pend_q <= 1'b1;
    end else if (reload_irq_clr) begin
      reload_pend_q <= 1'b0;
    end
  end
  assign reload_irq = reload_pend_q && reload_irq_en;

  // Comparator pin: three stages, trip once the last two are both high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      oc_sync_q <= 3'h0;
      oc_fault  <= 1'b0;
    end else begin
      oc_sync_q <= {oc_sync_q[1:0], oc_cmp_in};
      if (trip_now)
        oc_fault <= 1'b1;
      else if (oc_fault_clr)
        oc_fault <= 1'b0;
    end
  end
  assign trip_now = oc_sync_q[1] && oc_sync_q[2];
  assign kill     = !pwm_running || trip_now || oc_fault;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_phase
      logic [39:0] prod;
      logic        first_part;
      assign prod       = 40'(duty_act_q[ch]) * 40'(PWM_PERIOD_CYC);
      assign first_part = 32'(period_cnt_q) < prod[39:8];
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          demand_q[ch] <= 1'b0;
        end else begin
          demand_q[ch] <= pol_act_q[ch] ? first_part : !first_part;
        end
      end
      dead_time_pair #(
        .DEAD_CYC (DEAD_CYC)
      ) u_pair (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .demand  (demand_q[ch]),
        .kill    (kill),
        .high_on (gate_high[ch]),
        .low_on  (gate_low[ch])
      );
    end
  endgenerate

  // Tach pin: filtered level moves only when the last two stages agree
  assign tach_rise = (tach_sync_q[1] == tach_sync_q[2]) &&
                     tach_sync_q[2] && !tach_lvl_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tach_sync_q <= 3'h0;
      tach_lvl_q  <= 1'b0;
    end else begin
      tach_sync_q <= {tach_sync_q[1:0], tach_in};
      if (tach_sync_q[1] == tach_sync_q[2])
        tach_lvl_q <= tach_sync_q[2];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      speed_cnt_q  <= 16'h0000;
      rolled_q     <= 1'b0;
      speed_period <= `SPEED_MAX;
      speed_valid  <= 1'b0;
    end else begin
      speed_valid <= tach_rise;
      if (tach_rise) begin
        speed_period <= rolled_q ? `SPEED_MAX : speed_cnt_q;
        speed_cnt_q  <= 16'h0000;
        rolled_q     <= 1'b0;
      end else begin
        speed_cnt_q <= speed_cnt_q + 16'h0001;
        if (speed_cnt_q == `SPEED_MAX)
          rolled_q <= 1'b1;
      end
    end
  end

  property p_osc_settle;
    @(posedge ref_clk) disable iff (!resetn)
      (osc_q == motor_pwm_pkg::OSC_SETTLE) && (osc_wait_q != 32'h0)
      |=> (osc_q == motor_pwm_pkg::OSC_SETTLE);
  endproperty
  a_osc_settle: assert property (p_osc_settle)
    else $error("oscillator left settling early");

  property p_reload_adc;
    @(posedge ref_clk) disable iff (!resetn)
      reload_tick |=> adc_start && reload_pend_q;
  endproperty
  a_reload_adc: assert property (p_reload_adc)
    else $error("reload did not start conversion and pend request");

  property p_pend_hold;
    @(posedge ref_clk) disable iff (!resetn)
      reload_pend_q && !reload_irq_clr |=> reload_pend_q;
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("reload request lost without clear");

  // While the request is out, the pairs still see the old cycle's last demand
  property p_sample_first;
    @(posedge ref_clk) disable iff (!resetn)
      adc_start && pwm_running |-> (demand_q == ~$past(pol_act_q));
  endproperty
  a_sample_first: assert property (p_sample_first)
    else $error("new gate state ahead of current sample");

  property p_shadow;
    @(posedge ref_clk) disable iff (!resetn)
      !load_act |=> $stable(duty_act_q) && $stable(pol_act_q);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("active duty changed outside reload");

  property p_trip_off;
    @(posedge ref_clk) disable iff (!resetn)
      trip_now |=> (gate_high == 3'h0) && (gate_low == 3'h0) && oc_fault;
  endproperty
  a_trip_off: assert property (p_trip_off)
    else $error("overcurrent did not shut outputs");

  property p_fault_hold;
    @(posedge ref_clk) disable iff (!resetn)
      oc_fault |=> (gate_high == 3'h0) && (gate_low == 3'h0);
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("outputs active during fault");

  property p_relay_order;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(relay_en) |->
        ($past(seq_q) == motor_pwm_pkg::SEQ_PRECHARGE) &&
        ($past(seq_wait_q) == 32'h0) && !pwm_running;
  endproperty
  a_relay_order: assert property (p_relay_order)
    else $error("relay closed before precharge done");

  property p_capture;
    @(posedge ref_clk) disable iff (!resetn)
      tach_rise |=> (speed_cnt_q == 16'h0000) &&
      (speed_period == ($past(rolled_q) ? `SPEED_MAX : $past(speed_cnt_q)));
  endproperty
  a_capture: assert property (p_capture)
    else $error("tach capture wrong");

endmodule // motor_pwm_frontend
`default_nettype wire

// ==== bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bridge_model #(
  parameter int DEAD = 12
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] gate_high,
  input  wire logic [2:0] gate_low,
  input  wire logic       adc_start,
  output logic            adc_done,
  output logic [7:0]      adc_data,
  output int              faults
);
  int         off_hi[3];
  int         off_lo[3];
  logic [2:0] hi_q;
  logic [2:0] lo_q;
  logic [1:0] conv_q;

  // Between results the data lines toggle, so a stale read cannot pass
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conv_q   <= 2'h0;
      adc_done <= 1'b0;
      adc_data <= 8'h00;
    end else begin
      conv_q   <= {conv_q[0], adc_start};
      adc_done <= conv_q[1];
      adc_data <= conv_q[1] ? 8'(8'h78 + $urandom_range(15)) : ~adc_data;
    end
  end

  // Counters start at DEAD: gates were off for the whole reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      faults <= 0;
      hi_q   <= 3'h0;
      lo_q   <= 3'h0;
      off_hi <= '{default: DEAD};
      off_lo <= '{default: DEAD};
    end else begin
      hi_q <= gate_high;
      lo_q <= gate_low;
      for (int i = 0; i < 3; i++) begin
        off_hi[i] <= gate_high[i] ? 0 : off_hi[i] + 1;
        off_lo[i] <= gate_low[i] ? 0 : off_lo[i] + 1;
        if ((gate_high[i] && gate_low[i]) ||
            (gate_high[i] && !hi_q[i] && off_lo[i] < DEAD) ||
            (gate_low[i] && !lo_q[i] && off_hi[i] < DEAD))
          faults <= faults + 1;
      end
    end
  end
endmodule // bridge_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PER = 64;
  localparam int DEAD = 12;
  logic                 ref_clk, resetn, osc_wr, startup_done;
  logic                 reload_irq_en, reload_irq_clr, adc_done, tach_in;
  logic                 oc_cmp_in, oc_fault_clr, ext_osc_en, sys_clk_sel;
  logic                 relay_en, pwm_running, reload_irq, adc_start;
  logic                 current_valid, cal_done, speed_valid, oc_fault;
  logic [7:0]           osc_wr_data, adc_data, cal_offset, last_adc, e_off;
  logic [2:0][7:0]      duty;
  logic [2:0]           pwm_polarity_control, gate_high, gate_low;
  logic signed [8:0]    current_sample;
  logic [15:0]          speed_period;
  logic [10:0]          cal_sum;
  int                   miscompares, n_checks, faults, n_adc, cnt, t;
  int                   hc[3];

  motor_pwm_frontend #(.PWM_PERIOD_CYC(PER), .DEAD_CYC(DEAD),
    .OSC_SETTLE_CYC(20), .PRECHARGE_CYC(30), .CONTACT_SETTLE_CYC(20)) uut (
    .ref_clk, .resetn, .osc_wr, .osc_wr_data, .ext_osc_en, .sys_clk_sel,
    .startup_done, .relay_en, .pwm_running, .duty, .pwm_polarity_control,
    .reload_irq_en, .reload_irq_clr, .reload_irq, .adc_start, .adc_done,
    .adc_data, .current_sample, .current_valid, .cal_offset, .cal_done,
    .tach_in, .speed_period, .speed_valid, .oc_cmp_in, .oc_fault_clr,
    .oc_fault, .gate_high, .gate_low);

  bridge_model #(.DEAD(DEAD)) far (.ref_clk, .resetn, .gate_high, .gate_low,
    .adc_start, .adc_done, .adc_data, .faults);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Sampled before the edge's updates, as the design sees it
  always @(posedge ref_clk) if (adc_done === 1'b1) begin
    if (n_adc < 8) cal_sum += adc_data;
    n_adc++;
    last_adc = adc_data;
  end

  task automatic tick;
    @(negedge ref_clk);
  endtask

  // High-side on time: duty share of the period less the dead time
  function automatic logic [15:0] on_cycles(input logic [7:0] d);
    return 16'(((d * PER) >> 8) - DEAD);
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic osc_seq(input logic [7:0] a, b, c);
    logic [7:0] v[3];
    v = '{a, b, c};
    osc_wr = 1'b1;
    foreach (v[i]) begin
      osc_wr_data = v[i];
      tick;
    end
    osc_wr = 1'b0;
    tick;
  endtask

  task automatic sync;
    cnt = 0;
    do begin
      tick;
      cnt++;
    end while (adc_start !== 1'b1 && cnt < 300);
    chk("reload seen", 16'h0001, 16'(adc_start));
  endtask

  task automatic tach(input int p);
    tach_in = 1'b1;
    repeat (4) tick;
    chk("speed valid", 16'h0001, 16'(speed_valid));
    tick;
    tach_in = 1'b0;
    repeat (p - 5) tick;
  endtask

  initial begin
    #(100000 * 50);
    miscompares++;
    close_out;
  end

  initial begin
    {resetn, osc_wr, osc_wr_data, startup_done, reload_irq_en} = '0;
    {reload_irq_clr, tach_in, oc_cmp_in, oc_fault_clr} = '0;
    duty = '0;
    pwm_polarity_control = 3'h7;
    cal_sum = '0;
    void'($urandom(4208));
    repeat (5) tick;
    resetn = 1'b1;
    tick;
    chk("offset", 16'h0080, cal_offset);
    chk("period", 16'hFFFF, speed_period);
    chk("relay", 16'h0000, {relay_en, pwm_running, gate_high, gate_low});
    osc_seq(8'hE7, 8'h55, 8'h01);
    chk("osc bad key", 16'h0000, ext_osc_en);
    osc_seq(8'hE7, 8'h18, 8'h01);
    chk("osc enable", 16'h0001, ext_osc_en);
    osc_seq(8'hE7, 8'h18, 8'h02);
    chk("switch in settle", 16'h0000, sys_clk_sel);
    repeat (25) tick;
    osc_seq(8'hE7, 8'h18, 8'h02);
    chk("switch", 16'h0001, sys_clk_sel);
    startup_done = 1'b1;
    for (cnt = 0; cal_done !== 1'b1 && cnt < 500; cnt++) tick;
    chk("cal done", 16'h0001, 16'(cal_done));
    e_off = cal_sum[10:3];
    chk("cal offset", 16'(e_off), cal_offset);
    chk("relay early", 16'h0000, relay_en);
    for (cnt = 0; relay_en !== 1'b1 && cnt < 200; cnt++) tick;
    chk("precharge", 16'h0001, 16'(cnt >= 28 && cnt <= 32));
    for (cnt = 0; pwm_running !== 1'b1 && cnt < 200; cnt++) tick;
    chk("settle", 16'h0001, 16'(cnt >= 18 && cnt <= 22));
    sync;
    sync;
    chk("reload period", 16'(PER), 16'(cnt));
    repeat (4) tick;
    chk("current valid", 16'h0001, 16'(current_valid));
    chk("current", 16'(signed'({1'b0, last_adc} - {1'b0, e_off})),
        16'(current_sample));
    reload_irq_clr = 1'b1;
    tick;
    reload_irq_clr = 1'b0;
    sync;
    tick;
    chk("irq masked", 16'h0000, reload_irq);
    reload_irq_en = 1'b1;
    tick;
    chk("irq pending", 16'h0001, reload_irq);
    reload_irq_clr = 1'b1;
    tick;
    reload_irq_clr = 1'b0;
    tick;
    chk("irq cleared", 16'h0000, reload_irq);
    for (int p = 0; p < 2; p++) begin
      pwm_polarity_control = p ? 3'h7 : 3'h0;
      sync;
      sync;
      repeat (30) tick;
      chk("start high", p ? 16'h0 : 16'h7, gate_high);
      chk("start low", p ? 16'h7 : 16'h0, gate_low);
    end
    foreach (duty[i]) duty[i] = 8'($urandom_range(255, 128));
    // Top duty moves a gate on the edge right after the reload
    duty[0] = 8'hFF;
    sync;
    sync;
    hc = '{0, 0, 0};
    repeat (PER) begin
      tick;
      foreach (hc[i]) hc[i] += gate_high[i];
    end
    foreach (hc[i])
      chk("on time", on_cycles(duty[i]), 16'(hc[i]));
    duty = '0;
    repeat (25) tick;
    chk("held duty", 16'h0007, gate_high);
    sync;
    repeat (25) tick;
    chk("new duty", 16'h0000, gate_high);
    pwm_polarity_control = 3'h0;
    sync;
    sync;
    oc_cmp_in = 1'b1;
    repeat (6) tick;
    chk("trip", 16'h0001, oc_fault);
    chk("trip gates", 16'h0000, {gate_high, gate_low});
    oc_fault_clr = 1'b1;
    repeat (3) tick;
    chk("trip wins", 16'h0001, oc_fault);
    oc_fault_clr = 1'b0;
    oc_cmp_in = 1'b0;
    repeat (6) tick;
    chk("trip held", 16'h0000, {oc_fault, gate_high, gate_low} ^ 7'h40);
    oc_fault_clr = 1'b1;
    repeat (2) tick;
    oc_fault_clr = 1'b0;
    tick;
    chk("trip clear", 16'h0000, oc_fault);
    repeat (30) tick;
    chk("gates back", 16'h0007, gate_high);
    tach(50);
    repeat (3) begin
      t = $urandom_range(2000, 100);
      tach(t);
      tach(10);
      chk("speed", 16'h0001, 16'(speed_period inside {[t - 1:t]}));
    end
    tach(66000);
    tach(10);
    chk("rollover", 16'hFFFF, speed_period);
    chk("bridge", 16'h0000, 16'(faults));
    close_out;
  end
endmodule // tb
`default_nettype wire
